/* logic/spisp_cfg.svh */
// register map, field positions and constants of the serial port
`ifndef SPISP_CFG_SVH
`define SPISP_CFG_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SPISP_OFS_STAT 4'h0
`define SPISP_OFS_CON1 4'h4
`define SPISP_OFS_CON2 4'h8
`define SPISP_OFS_BUF 4'hc
// ----------------------------------------------------------------
// status and control bits
// ----------------------------------------------------------------
`define SPISP_STAT_EN 15
`define SPISP_STAT_SIDL 13
`define SPISP_STAT_OVF 6
`define SPISP_STAT_TBF 1
`define SPISP_STAT_RBF 0
`define SPISP_STAT_WMASK 16'ha000
// ----------------------------------------------------------------
// control one bits
// ----------------------------------------------------------------
`define SPISP_C1_CKDIS 12
`define SPISP_C1_OUTDIS 11
`define SPISP_C1_W16 10
`define SPISP_C1_SMP 9
`define SPISP_C1_CKE 8
`define SPISP_C1_SELECT_ENABLE 7
`define SPISP_C1_CKP 6
`define SPISP_C1_MASTER_ENABLE 5
`define SPISP_C1_SECONDARY_PRESCALE 4:2
`define SPISP_C1_PRIMARY_PRESCALE 1:0
`define SPISP_C1_MASK 16'h1fff
// ----------------------------------------------------------------
// control two bits
// ----------------------------------------------------------------
`define SPISP_C2_FEN 15
`define SPISP_C2_FSD 14
`define SPISP_C2_FPOL 13
`define SPISP_C2_FDLY 1
`define SPISP_C2_MASK 16'he002
// ----------------------------------------------------------------
// word sizes and clock divider
// ----------------------------------------------------------------
`define SPISP_BITS_WORD 5'd16
`define SPISP_BITS_BYTE 5'd8
`define SPISP_MSB_WORD 4'd15
`define SPISP_MSB_BYTE 4'd7
`define SPISP_SECONDARY_PRESCALE_BASE 4'd8
`define SPISP_PRIMARY_PRESCALE_SH4 2
`define SPISP_PRIMARY_PRESCALE_SH16 4
`define SPISP_PRIMARY_PRESCALE_SH64 6
`define SPISP_RST_WORD 16'h0000
`endif

/* logic/spisp_pkg.sv */
// types shared by the serial port design
`default_nettype none
package spisp_pkg;
   typedef enum logic [1:0] {
      SPISP_IDLE = 2'b00,
      SPISP_PRE = 2'b01,
      SPISP_XFER = 2'b10
   } spisp_st_e;

   typedef struct packed {
      spisp_st_e st;
      logic sck;
      logic [9:0] div;
      logic [4:0] bitcnt;
      logic [4:0] leads;
      logic [15:0] sr;
      logic samp;
      logic sdo;
      logic [15:0] txb;
      logic [15:0] rxb;
      logic tbf;
      logic rbf;
      logic ovf;
      logic [15:0] stat_ctl;
      logic [15:0] con1;
      logic [15:0] con2;
      logic ack;
      logic sck_d;
   } spisp_state_s;
endpackage : spisp_pkg
`default_nettype wire

/* logic/spisp_sync.sv */
// synchroniser of STAGES stages (at least two, two by default) for pins entering the system clock domain
`timescale 1ns/1ps
`default_nettype none
module spisp_sync #(
   parameter int STAGES = 2,
   parameter int WIDTH = 1
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic [WIDTH-1:0] ASYNC_IN,
   output logic [WIDTH-1:0] SYNC_OUT
);
   if (STAGES < 2) begin : g_chk
      $error("spisp_sync needs at least two stages");
   end

   // ----------------------------------------------------------------
   // one chain per bit, only the last stage is visible
   // ----------------------------------------------------------------
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic [STAGES-1:0] chain_reg;
      logic [STAGES-1:0] chain_next;
      always_comb begin
         chain_next = {chain_reg[STAGES-2:0], ASYNC_IN[i]};
      end
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
         if (!RST_N) begin
            chain_reg <= '0;
         end else begin
            chain_reg <= chain_next;
         end
      end
      assign SYNC_OUT[i] = chain_reg[STAGES-1];
   end
endmodule : spisp_sync
`default_nettype wire

/* logic/spisp_top.sv */
// framed serial port with avalon-mm register access
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "spisp_cfg.svh"
module spisp_top
   import spisp_pkg::*;
#(
   parameter int SYNC_STAGES = 2
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic SERIAL_IN_PIN,
   output logic SERIAL_OUT_PIN,
   output logic SERIAL_OUT_PIN_OE,
   input wire logic SHIFT_CLOCK_PIN_I,
   output logic SHIFT_CLOCK_PIN_O,
   output logic SHIFT_CLOCK_PIN_OE,
   input wire logic SELECT_LOW_PIN_I,
   output logic SELECT_LOW_PIN_O,
   output logic SELECT_LOW_PIN_OE
);
   if (SYNC_STAGES < 2) begin : g_chk
      $error("spisp_top needs SYNC_STAGES of at least two");
   end

   spisp_state_s state_reg;
   spisp_state_s state_next;
   logic [2:0] pin_s;

   // ----------------------------------------------------------------
   // pin synchronisers: {select, data in, shift clock}
   // ----------------------------------------------------------------
   spisp_sync #(.STAGES(SYNC_STAGES), .WIDTH(3)) u_sync (
      .CLK_SYS(CLK_SYS),
      .RST_N(RST_N),
      .ASYNC_IN({SELECT_LOW_PIN_I, SERIAL_IN_PIN, SHIFT_CLOCK_PIN_I}),
      .SYNC_OUT(pin_s)
   );

   // ----------------------------------------------------------------
   // configuration decode
   // ----------------------------------------------------------------
   function automatic logic [9:0] spisp_half(input logic [1:0] pp, input logic [2:0] sp);
      logic [9:0] base;
      base = {6'h00, `SPISP_SECONDARY_PRESCALE_BASE - {1'b0, sp}};
      case (pp)
         2'b11: spisp_half = base;
         2'b10: spisp_half = base << `SPISP_PRIMARY_PRESCALE_SH4;
         2'b01: spisp_half = base << `SPISP_PRIMARY_PRESCALE_SH16;
         default: spisp_half = base << `SPISP_PRIMARY_PRESCALE_SH64;
      endcase
   endfunction : spisp_half

   logic en, mst, cpol, w16, select_enable, fen, fsd, fpol, fdly, cke_eff, ckdis, outdis;
   logic [4:0] nbits;
   logic [3:0] msb;
   logic [9:0] half;
   logic sel_in, sdi_s, sck_s, fs_act;
   assign en = state_reg.stat_ctl[`SPISP_STAT_EN];
   assign mst = state_reg.con1[`SPISP_C1_MASTER_ENABLE];
   assign cpol = state_reg.con1[`SPISP_C1_CKP];
   assign w16 = state_reg.con1[`SPISP_C1_W16];
   assign select_enable = state_reg.con1[`SPISP_C1_SELECT_ENABLE];
   assign ckdis = state_reg.con1[`SPISP_C1_CKDIS];
   assign outdis = state_reg.con1[`SPISP_C1_OUTDIS];
   assign fen = state_reg.con2[`SPISP_C2_FEN];
   assign fsd = state_reg.con2[`SPISP_C2_FSD];
   assign fpol = state_reg.con2[`SPISP_C2_FPOL];
   assign fdly = state_reg.con2[`SPISP_C2_FDLY];
   assign cke_eff = state_reg.con1[`SPISP_C1_CKE] & ~fen;
   assign nbits = w16 ? `SPISP_BITS_WORD : `SPISP_BITS_BYTE;
   assign msb = w16 ? `SPISP_MSB_WORD : `SPISP_MSB_BYTE;
   assign half = spisp_half(state_reg.con1[`SPISP_C1_PRIMARY_PRESCALE], state_reg.con1[`SPISP_C1_SECONDARY_PRESCALE]);
   assign sck_s = pin_s[0];
   assign sdi_s = pin_s[1];
   assign sel_in = pin_s[2];
   assign fs_act = (sel_in == fpol);

   // ----------------------------------------------------------------
   // bus handshake: one wait cycle, then the request is taken
   // ----------------------------------------------------------------
   logic bus_req, wr_acc, rd_acc, buf_wr, buf_rd;
   logic [15:0] wmask;
   assign bus_req = AVS_READ | AVS_WRITE;
   assign wr_acc = AVS_WRITE & state_reg.ack;
   assign rd_acc = AVS_READ & state_reg.ack;
   assign buf_wr = wr_acc && (AVS_ADDRESS == `SPISP_OFS_BUF) && (|AVS_BYTEENABLE[1:0]);
   assign buf_rd = rd_acc && (AVS_ADDRESS == `SPISP_OFS_BUF);
   assign wmask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
   assign AVS_WAITREQUEST = bus_req & ~state_reg.ack;

   always_comb begin
      AVS_READDATA = 32'h0000_0000;
      if (rd_acc) begin
         case (AVS_ADDRESS)
            `SPISP_OFS_STAT: begin
               AVS_READDATA[15:0] = state_reg.stat_ctl;
               AVS_READDATA[`SPISP_STAT_OVF] = state_reg.ovf;
               AVS_READDATA[`SPISP_STAT_TBF] = state_reg.tbf;
               AVS_READDATA[`SPISP_STAT_RBF] = state_reg.rbf;
            end
            `SPISP_OFS_CON1: AVS_READDATA[15:0] = state_reg.con1;
            `SPISP_OFS_CON2: AVS_READDATA[15:0] = state_reg.con2;
            `SPISP_OFS_BUF: AVS_READDATA[15:0] = state_reg.rxb;
            default: AVS_READDATA = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // clock events: generated in master, found on the pin in slave
   // ----------------------------------------------------------------
   logic tick, lead, trail, s_edge, m_start, s_sel, s_go, s_imm, lead_act, abort;
   assign tick = mst && (state_reg.st != SPISP_IDLE) && (state_reg.div == half - 10'd1);
   assign s_edge = ~mst && (sck_s != state_reg.sck_d);
   assign lead = mst ? (tick && (state_reg.sck == cpol)) : (s_edge && (sck_s != cpol));
   assign trail = mst ? (tick && (state_reg.sck != cpol)) : (s_edge && (sck_s == cpol));
   assign m_start = en && mst && (state_reg.st == SPISP_IDLE) && state_reg.tbf
      && (~fen || ~fsd || fs_act);
   // in framed mode the select enable is not looked at
   assign s_sel = fen | ~select_enable | ~sel_in;
   assign s_go = en && ~mst && (state_reg.st == SPISP_IDLE) && lead && s_sel
      && (~fen || ~fsd || fs_act);
   assign s_imm = s_go && ~(fen && fsd && ~fdly);
   assign lead_act = lead && ((state_reg.st == SPISP_XFER) || s_imm);
   assign abort = ~en || (~mst && ~s_sel && (state_reg.st != SPISP_IDLE));

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic done;
   logic rxbit;
   logic [15:0] shifted;
   logic [15:0] rx_word;
   always_comb begin
      state_next = state_reg;
      done = 1'b0;
      rxbit = 1'b0;
      shifted = state_reg.sr;
      rx_word = state_reg.rxb;
      state_next.sck_d = sck_s;
      state_next.ack = bus_req & ~state_reg.ack;
      // software register writes and clears first, so hardware sets below win; the buffer write goes last
      if (wr_acc) begin
         case (AVS_ADDRESS)
            `SPISP_OFS_STAT: begin
               state_next.stat_ctl = (state_reg.stat_ctl & ~(wmask & `SPISP_STAT_WMASK))
                  | (AVS_WRITEDATA[15:0] & wmask & `SPISP_STAT_WMASK);
               if (AVS_BYTEENABLE[0] && !AVS_WRITEDATA[`SPISP_STAT_OVF]) begin
                  state_next.ovf = 1'b0;
               end
            end
            `SPISP_OFS_CON1: state_next.con1 = (state_reg.con1 & ~(wmask & `SPISP_C1_MASK))
               | (AVS_WRITEDATA[15:0] & wmask & `SPISP_C1_MASK);
            `SPISP_OFS_CON2: state_next.con2 = (state_reg.con2 & ~(wmask & `SPISP_C2_MASK))
               | (AVS_WRITEDATA[15:0] & wmask & `SPISP_C2_MASK);
            default: state_next.ack = 1'b0;
         endcase
      end
      if (buf_rd) begin
         state_next.rbf = 1'b0;
      end
      // transfer engine
      case (state_reg.st)
         SPISP_IDLE: begin
            state_next.sck = cpol;
            state_next.div = 10'd0;
            state_next.bitcnt = 5'd0;
            state_next.leads = 5'd0;
            if (en && state_reg.tbf && (mst ? m_start : 1'b1)) begin
               state_next.sr = state_reg.txb;
               state_next.sdo = state_reg.txb[msb];
               state_next.tbf = 1'b0;
            end
            if (m_start) begin
               state_next.st = (fen && ~fsd && ~fdly) ? SPISP_PRE : SPISP_XFER;
            end
            if (s_go) begin
               state_next.st = SPISP_XFER;
            end
         end
         SPISP_PRE: begin
            if (trail) begin
               state_next.st = SPISP_XFER;
            end
         end
         SPISP_XFER: begin
            if (trail) begin
               rxbit = cke_eff ? state_reg.samp : sdi_s;
               shifted = {state_reg.sr[14:0], rxbit};
               state_next.sr = shifted;
               state_next.bitcnt = state_reg.bitcnt + 5'd1;
               if (cke_eff) begin
                  state_next.sdo = shifted[msb];
               end
               if (state_reg.bitcnt == nbits - 5'd1) begin
                  done = 1'b1;
                  state_next.st = SPISP_IDLE;
                  rx_word = w16 ? shifted : {8'h00, shifted[7:0]};
               end
            end
         end
         default: state_next.st = SPISP_IDLE;
      endcase
      if (mst && (state_reg.st != SPISP_IDLE)) begin
         state_next.div = tick ? 10'd0 : state_reg.div + 10'd1;
         if (tick) begin
            state_next.sck = ~state_reg.sck;
         end
      end
      if (lead_act) begin
         state_next.leads = state_reg.leads + 5'd1;
         if (cke_eff) begin
            state_next.samp = sdi_s;
         end else begin
            state_next.sdo = state_reg.sr[msb];
         end
      end
      if (done) begin
         if (state_next.rbf) begin
            state_next.ovf = 1'b1;
         end else begin
            state_next.rxb = rx_word;
            state_next.rbf = 1'b1;
         end
      end
      if (abort) begin
         state_next.st = SPISP_IDLE;
         state_next.bitcnt = 5'd0;
      end
      if (buf_wr) begin
         state_next.txb = (state_reg.txb & ~wmask) | (AVS_WRITEDATA[15:0] & wmask);
         state_next.tbf = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------
   logic fr_on;
   assign fr_on = (state_reg.st == SPISP_PRE)
      || ((state_reg.st == SPISP_XFER) && (state_reg.bitcnt == 5'd0) && fdly);
   assign SERIAL_OUT_PIN = state_reg.sdo;
   assign SERIAL_OUT_PIN_OE = en && ~outdis && (mst || fen || ~select_enable || ~sel_in);
   assign SHIFT_CLOCK_PIN_O = state_reg.sck;
   assign SHIFT_CLOCK_PIN_OE = en && mst && ~ckdis;
   assign SELECT_LOW_PIN_O = fr_on ? fpol : ~fpol;
   assign SELECT_LOW_PIN_OE = en && fen && ~fsd;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   sequence s_pre_to_xfer;
      (state_reg.st == SPISP_PRE) ##1 (state_reg.st == SPISP_XFER);
   endsequence

   property p_tbf_set;
      buf_wr |=> state_reg.tbf;
   endproperty
   a_tbf_set: assert property (p_tbf_set) else $error("tx full not set by write");

   property p_tbf_clr;
      (m_start && !buf_wr) |=> (!state_reg.tbf && state_reg.st != SPISP_IDLE);
   endproperty
   a_tbf_clr: assert property (p_tbf_clr) else $error("tx full kept after start");

   property p_rbf_set;
      (done && !state_reg.rbf) |=> (state_reg.rbf && state_reg.rxb == $past(rx_word));
   endproperty
   a_rbf_set: assert property (p_rbf_set) else $error("rx word not buffered");

   property p_ovf;
      (done && state_reg.rbf && !buf_rd) |=> (state_reg.ovf && $stable(state_reg.rxb));
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not flagged");

   property p_rd_clr;
      (buf_rd && !done) |=> !state_reg.rbf;
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("rx full kept after read");

   property p_width;
      done |-> (state_reg.leads == nbits);
   endproperty
   a_width: assert property (p_width) else $error("wrong bit count");

   property p_slave_clk;
      !mst |-> !SHIFT_CLOCK_PIN_OE;
   endproperty
   a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock");

   property p_pre_pulse;
      (state_reg.st == SPISP_PRE) |-> (SELECT_LOW_PIN_O == fpol && SELECT_LOW_PIN_OE);
   endproperty
   a_pre_pulse: assert property (p_pre_pulse) else $error("no early frame pulse");

   property p_frame_idle;
      (en && fen && !fsd && state_reg.st == SPISP_IDLE) |-> (SELECT_LOW_PIN_O == !fpol);
   endproperty
   a_frame_idle: assert property (p_frame_idle) else $error("frame level wrong");

   property p_no_frame;
      !fen |-> !SELECT_LOW_PIN_OE;
   endproperty
   a_no_frame: assert property (p_no_frame) else $error("select driven unframed");

   property p_pre_len;
      s_pre_to_xfer |-> $past(trail);
   endproperty
   a_pre_len: assert property (p_pre_len) else $error("early pulse not one clock");

   property p_coincide;
      (m_start && fen && !fsd && fdly) |=> (state_reg.st == SPISP_XFER && SELECT_LOW_PIN_O == fpol);
   endproperty
   a_coincide: assert property (p_coincide) else $error("pulse not with first bit");
endmodule : spisp_top
`default_nettype wire

/* testbench/spisp_partner.sv */
// far-side serial slave model clocked by the port's shift clock
`timescale 1ns/1ps
`default_nettype none
module spisp_partner (
   input wire logic sck,
   input wire logic mosi,
   input wire logic w16,
   input wire logic load,
   input wire logic [15:0] tx_word,
   output logic miso,
   output logic [15:0] rx_word
);
   logic [15:0] sh;
   int n;
   initial begin
      miso = 1'b1;
      rx_word = 16'h0000;
      sh = 16'h0000;
      n = 0;
   end
   always @(posedge load) begin
      sh = w16 ? tx_word : {tx_word[7:0], 8'h00};
      n = 0;
      rx_word = 16'h0000;
      miso = sh[15];
   end
   // sample on the leading edge of the clock the port drives
   always @(posedge sck) begin
      rx_word = {rx_word[14:0], mosi};
   end
   // shift on the trailing edge; after the last bit the line wanders
   always @(negedge sck) begin
      n = n + 1;
      sh = {sh[14:0], 1'b0};
      if (n >= (w16 ? 16 : 8)) begin
         miso = ~miso;
      end else begin
         miso = sh[15];
      end
   end
endmodule : spisp_partner
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the framed serial port
`timescale 1ns/1ps
`default_nettype none
`include "spisp_cfg.svh"
module tb_top;
   logic clk_sys, rst_n, av_read, av_write, sck_in, sel_in, p_load, p_w16, act_lvl;
   logic [3:0] av_addr, av_be;
   logic [31:0] av_wdata, rd;
   logic [15:0] p_tx;
   wire logic [31:0] av_rdata;
   wire logic av_wait, sdo, sdo_oe, sck_o, sck_oe, ss_o, ss_oe, miso, sck_w, mosi;
   wire logic [15:0] p_rx;
   int fails = 0;
   int n_checks = 0;
   int n_rise = 0;
   int n_act = 0;
   assign sck_w = sck_oe ? sck_o : 1'b0;
   assign mosi = sdo_oe ? sdo : ~sdo;

   spisp_top dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .AVS_ADDRESS(av_addr),
      .AVS_READ(av_read), .AVS_WRITE(av_write), .AVS_WRITEDATA(av_wdata),
      .AVS_BYTEENABLE(av_be), .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait),
      .SERIAL_IN_PIN(miso), .SERIAL_OUT_PIN(sdo), .SERIAL_OUT_PIN_OE(sdo_oe),
      .SHIFT_CLOCK_PIN_I(sck_in), .SHIFT_CLOCK_PIN_O(sck_o), .SHIFT_CLOCK_PIN_OE(sck_oe),
      .SELECT_LOW_PIN_I(sel_in), .SELECT_LOW_PIN_O(ss_o), .SELECT_LOW_PIN_OE(ss_oe));
   spisp_partner p_u (.sck(sck_w), .mosi(mosi), .w16(p_w16), .load(p_load),
      .tx_word(p_tx), .miso(miso), .rx_word(p_rx));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge sck_w) n_rise = n_rise + 1;
   always @(posedge clk_sys) if (ss_oe === 1'b1 && ss_o === act_lvl) n_act = n_act + 1;

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic print_verdict;
      if (fails == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic [3:0] a, input logic wr, input logic [15:0] d,
                      input logic [3:0] be = 4'h3);
      int i;
      @(posedge clk_sys);
      av_addr <= a;
      av_write <= wr;
      av_read <= ~wr;
      av_wdata <= {16'h0000, d};
      av_be <= be;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys);
         if (av_wait === 1'b0) break;
      end
      rd = av_rdata;
      av_write <= 1'b0;
      av_read <= 1'b0;
      if (i == 50) begin
         fails++;
         print_verdict();
      end
   endtask : bus
   task automatic wait_stat(input int b);
      int i;
      for (i = 0; i < 400; i++) begin
         bus(`SPISP_OFS_STAT, 1'b0, 16'h0000);
         if (rd[b] === 1'b1) break;
      end
      if (i == 400) begin
         fails++;
         print_verdict();
      end
   endtask : wait_stat
   task automatic load_p(input logic w, input logic [15:0] v);
      @(posedge clk_sys);
      p_w16 <= w;
      p_tx <= v;
      p_load <= 1'b1;
      @(posedge clk_sys);
      p_load <= 1'b0;
   endtask : load_p

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      logic [3:0] a[4];
      logic [15:0] w[4];
      logic [31:0] e[4];
      a = '{`SPISP_OFS_CON2, `SPISP_OFS_CON1, `SPISP_OFS_STAT, 4'h2};
      w = '{16'hffff, 16'hfffc, 16'hffff, 16'hffff};
      e = '{32'h0000e002, 32'h00001ffc, 32'h0000a000, 32'h00000000};
      for (int i = 0; i < 4; i++) begin
         bus(a[i], 1'b0, 16'h0000);
         chk("reset_value", rd, 32'h00000000);
         bus(a[i], 1'b1, w[i]);
         bus(a[i], 1'b0, 16'h0000);
         chk("readback", rd, e[i]);
         bus(a[i], 1'b1, 16'h0000);
      end
   endtask : t_regs
   task automatic t_master8;
      bus(`SPISP_OFS_CON1, 1'b1, 16'h0123);
      load_p(1'b0, 16'h00c3);
      bus(`SPISP_OFS_BUF, 1'b1, 16'h00a5);
      bus(`SPISP_OFS_STAT, 1'b0, 16'h0000);
      chk("tbf_held", rd, 32'h00000002);
      chk("sck_oe_off", sck_oe, 1'b0);
      bus(`SPISP_OFS_STAT, 1'b1, 16'h8000);
      bus(`SPISP_OFS_STAT, 1'b0, 16'h0000);
      chk("tbf_cleared", rd, 32'h00008000);
      chk("sck_oe_on", sck_oe, 1'b1);
      chk("sdo_oe_on", sdo_oe, 1'b1);
      chk("sel_oe_off", ss_oe, 1'b0);
      wait_stat(`SPISP_STAT_RBF);
      chk("rbf_set", rd, 32'h00008001);
      bus(`SPISP_OFS_BUF, 1'b0, 16'h0000);
      chk("rx_byte", rd, 32'h000000c3);
      chk("far_rx8", p_rx[7:0], 8'ha5);
      bus(`SPISP_OFS_STAT, 1'b0, 16'h0000);
      chk("rbf_clr", rd, 32'h00008000);
      bus(`SPISP_OFS_STAT, 1'b1, 16'h0000);
   endtask : t_master8
   task automatic t_master16_ovf;
      bus(`SPISP_OFS_CON1, 1'b1, 16'h0523);
      bus(`SPISP_OFS_STAT, 1'b1, 16'h8000);
      load_p(1'b1, 16'h9e71);
      bus(`SPISP_OFS_BUF, 1'b1, 16'h5ab4);
      wait_stat(`SPISP_STAT_RBF);
      chk("far_rx16", p_rx, 16'h5ab4);
      load_p(1'b1, 16'h1234);
      bus(`SPISP_OFS_BUF, 1'b1, 16'h0f0f);
      wait_stat(`SPISP_STAT_OVF);
      chk("ovf_set", rd, 32'h00008041);
      bus(`SPISP_OFS_BUF, 1'b0, 16'h0000);
      chk("rx_kept", rd, 32'h00009e71);
      bus(`SPISP_OFS_STAT, 1'b1, 16'h0000, 4'h1);
      bus(`SPISP_OFS_STAT, 1'b0, 16'h0000);
      chk("ovf_clr", rd, 32'h00008000);
      bus(`SPISP_OFS_STAT, 1'b1, 16'h0000);
   endtask : t_master16_ovf
   task automatic t_framed(input logic pol, input logic dly);
      bus(`SPISP_OFS_CON1, 1'b1, 16'h0023);
      bus(`SPISP_OFS_CON2, 1'b1, {2'b10, pol, 11'h000, dly, 1'b0});
      bus(`SPISP_OFS_STAT, 1'b1, 16'h8000);
      // let the enable settle before looking at the pins
      @(negedge clk_sys);
      act_lvl = pol;
      chk("frame_oe", ss_oe, 1'b1);
      chk("frame_idle", ss_o, !pol);
      n_rise = 0;
      n_act = 0;
      bus(`SPISP_OFS_BUF, 1'b1, 16'h0081);
      wait_stat(`SPISP_STAT_RBF);
      chk("frame_clocks", n_rise, dly ? 32'd8 : 32'd9);
      chk("frame_pulse", n_act != 0, 1'b1);
      bus(`SPISP_OFS_BUF, 1'b0, 16'h0000);
      bus(`SPISP_OFS_STAT, 1'b1, 16'h0000);
      bus(`SPISP_OFS_CON2, 1'b1, 16'h0000);
   endtask : t_framed
   task automatic t_slave;
      logic [7:0] got;
      got = 8'h00;
      bus(`SPISP_OFS_CON1, 1'b1, 16'h0000);
      bus(`SPISP_OFS_CON2, 1'b1, 16'hc002);
      bus(`SPISP_OFS_STAT, 1'b1, 16'h8000);
      bus(`SPISP_OFS_BUF, 1'b1, 16'h0066);
      @(negedge clk_sys);
      chk("slave_sck_oe", sck_oe, 1'b0);
      chk("slave_sel_oe", ss_oe, 1'b0);
      // bench is the far master: 160 ns shift clock, active-low frame with bit 0
      @(posedge clk_sys);
      sel_in <= 1'b0;
      for (int b = 0; b < 16; b++) begin
         repeat (8) @(posedge clk_sys);
         if (b % 2 == 1) begin
            got = {got[6:0], sdo};
         end
         sck_in <= ~sck_in;
         sel_in <= (b != 0);
      end
      wait_stat(`SPISP_STAT_RBF);
      chk("slave_rbf", rd, 32'h00008001);
      chk("slave_tx", got, 8'h66);
      bus(`SPISP_OFS_BUF, 1'b0, 16'h0000);
      bus(`SPISP_OFS_STAT, 1'b1, 16'h0000);
      bus(`SPISP_OFS_CON2, 1'b1, 16'h0000);
   endtask : t_slave

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      av_read = 1'b0;
      av_write = 1'b0;
      av_addr = 4'h0;
      av_wdata = 32'h00000000;
      av_be = 4'h3;
      sck_in = 1'b0;
      sel_in = 1'b1;
      p_load = 1'b0;
      p_w16 = 1'b0;
      p_tx = 16'h0000;
      act_lvl = 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_regs();
      t_master8();
      t_master16_ovf();
      for (int k = 0; k < 4; k++) t_framed(k[1], k[0]);
      t_slave();
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
